// ### common/pph_map.vh
// register map, field positions and constants for the parallel port host block
// included by rtl files; definitions only
`ifndef PPH_MAP_VH
`define PPH_MAP_VH
`define PPH_ADDR_W 11
`define PPH_OFF_FIFO 11'h400
`define PPH_OFF_DATA 11'h000
`define PPH_OFF_CTRL 11'h002
`define PPH_OFF_CFGA 11'h401
`define PPH_OFF_MODE 11'h402
`define PPH_MODE_SPP 3'h0
`define PPH_MODE_BIDIR 3'h1
`define PPH_MODE_FIFO 3'h2
`define PPH_MODE_ECP 3'h3
`define PPH_CTRL_STROBE 0
`define PPH_CTRL_AUTOFD 1
`define PPH_CTRL_INIT 2
`define PPH_CTRL_SELIN 3
`define PPH_CTRL_DIR 5
`define PPH_CTRL_RST 8'h04
`define PPH_WORD_CODE_1B 3'h1
`define PPH_FIFO_DEPTH 16
`define PPH_FIFO_AW 4
`define PPH_CNT_W 5
`define PPH_CLK_NS 25
`define PPH_STROBE_NS 500
`define PPH_STROBE_CYC ((`PPH_STROBE_NS + `PPH_CLK_NS - 1) / `PPH_CLK_NS)
`define PPH_CYC_W 6
`endif

// ### rtl/pph_fifo.v
// forward transmit fifo, 8 bit words, fixed depth
// ignores writes when full and reads when empty; flush clears it
`timescale 1ns/10ps
`include "pph_map.vh"
module pph_fifo (
    input wire clk,
    input wire reset,
    input wire flush,
    input wire wr_valid,
    output wire wr_ready,
    input wire [7:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [7:0] rd_data,
    output wire full,
    output wire empty
);
    reg [7:0] mem [0:`PPH_FIFO_DEPTH-1];
    reg [`PPH_FIFO_AW-1:0] wr_ptr;
    reg [`PPH_FIFO_AW-1:0] rd_ptr;
    reg [`PPH_CNT_W-1:0] count;
    wire do_wr;
    wire do_rd;
    assign full = (count == `PPH_FIFO_DEPTH);
    assign empty = (count == {`PPH_CNT_W{1'b0}});
    assign wr_ready = ~full;
    assign rd_valid = ~empty;
    assign rd_data = mem[rd_ptr];
    assign do_wr = wr_valid & ~full;
    assign do_rd = rd_ready & ~empty;
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end
    always @(posedge clk) begin
        if (reset || flush) begin
            wr_ptr <= {`PPH_FIFO_AW{1'b0}};
            rd_ptr <= {`PPH_FIFO_AW{1'b0}};
            count <= {`PPH_CNT_W{1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ### rtl/pph_port.v
// host parallel port: control override, direction, fifo mode, configuration a
// assumes a simple synchronous register port; peripheral pins synchronous to clk
`timescale 1ns/10ps
`include "pph_map.vh"
module pph_port #(
    parameter LEVEL_IRQ = 1'b0,
    parameter TRANSCEIVER_FLAG = 1'b1
) (
    input wire clk,
    input wire reset,
    input wire [`PPH_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire reg_wr_ready,
    input wire [7:0] pd_in,
    output reg [7:0] pd_out,
    output wire pd_oe,
    output wire n_strobe,
    output wire n_auto_fd,
    output wire n_reverse_request,
    output wire n_select_in,
    input wire n_ack,
    input wire busy,
    input wire n_ack_reverse,
    input wire n_periph_request,
    input wire select
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SETUP = 2'h1;
    localparam ST_STROBE = 2'h2;
    localparam ST_WAIT = 2'h3;
    reg [7:0] ctrl;
    reg [2:0] mode;
    reg cfg_misc;
    reg [1:0] partial;
    reg [1:0] state;
    reg [`PPH_CYC_W-1:0] cyc;
    reg hw_strobe;
    wire fifo_full;
    wire fifo_empty;
    wire fifo_rd_valid;
    wire fifo_wr_ready;
    wire [7:0] fifo_rd_data;
    wire fifo_pop;
    wire fifo_push;
    wire fifo_flush;
    wire hw_mode;
    wire [7:0] cfg_a;
    wire [7:0] status;

    function hit;
        input [`PPH_ADDR_W-1:0] a;
        input [`PPH_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // partial is cleared only on the way from 011 back to 000 or 001
    function leaves_ecp;
        input [2:0] cur;
        input [2:0] nxt;
        begin
            leaves_ecp = (cur == `PPH_MODE_ECP) && (nxt == `PPH_MODE_SPP || nxt == `PPH_MODE_BIDIR);
        end
    endfunction

    // fifo mode is forward only: direction never reverses it
    assign hw_mode = (mode == `PPH_MODE_FIFO);
    assign fifo_push = reg_wr & hit(reg_addr, `PPH_OFF_FIFO) & hw_mode;
    assign reg_wr_ready = fifo_wr_ready;
    // leaving fifo mode discards any queued words
    assign fifo_flush = reg_wr & hit(reg_addr, `PPH_OFF_MODE) & (reg_wdata[2:0] != mode) & hw_mode;
    // pop only once the peripheral took the byte, so full still counts it
    assign fifo_pop = (state == ST_WAIT) & ~busy & n_ack;

    pph_fifo u_fifo (
        .clk(clk),
        .reset(reset),
        .flush(fifo_flush),
        .wr_valid(fifo_push),
        .wr_ready(fifo_wr_ready),
        .wr_data(reg_wdata),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_rd_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // drivers stay on in modes 000 and 010 whatever the direction bit
    assign pd_oe = (mode == `PPH_MODE_SPP) | hw_mode | ~ctrl[`PPH_CTRL_DIR];
    // software bits or the machine, so a stalled machine can be overridden
    assign n_strobe = ~(ctrl[`PPH_CTRL_STROBE] | hw_strobe);
    assign n_auto_fd = ~ctrl[`PPH_CTRL_AUTOFD];
    // abort handshake is driven by software through the init bit
    assign n_reverse_request = ctrl[`PPH_CTRL_INIT];
    assign n_select_in = ~ctrl[`PPH_CTRL_SELIN];
    // request line is only reported, never required high
    assign status = {~busy, n_ack, n_ack_reverse, select, n_periph_request, 3'h0};

    // 1-byte port word, so bits 1:0 always read complete on this design
    assign cfg_a = {LEVEL_IRQ, `PPH_WORD_CODE_1B, cfg_misc, TRANSCEIVER_FLAG, partial};

    always @(posedge clk) begin
        if (reset) begin
            ctrl <= `PPH_CTRL_RST;
            mode <= `PPH_MODE_SPP;
            cfg_misc <= 1'b0;
            partial <= 2'h0;
        end else if (reg_wr) begin
            if (hit(reg_addr, `PPH_OFF_CTRL)) begin
                ctrl <= {2'h0, reg_wdata[5:0]};
            end
            if (hit(reg_addr, `PPH_OFF_CFGA)) begin
                cfg_misc <= reg_wdata[3];
            end
            if (hit(reg_addr, `PPH_OFF_MODE)) begin
                mode <= reg_wdata[2:0];
                if (leaves_ecp(mode, reg_wdata[2:0])) begin
                    // word is one byte wide so no fraction is ever left
                    partial <= 2'h0;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pd_out <= 8'h00;
        end else if (hw_mode && state == ST_IDLE && fifo_rd_valid && !busy) begin
            pd_out <= fifo_rd_data;
        end else if (reg_wr && hit(reg_addr, `PPH_OFF_DATA) && !hw_mode) begin
            pd_out <= reg_wdata;
        end
    end

    // standard handshake: setup, strobe pulse, wait for busy to drop
    always @(posedge clk) begin
        if (reset || !hw_mode) begin
            state <= ST_IDLE;
            cyc <= {`PPH_CYC_W{1'b0}};
            hw_strobe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // a busy peripheral stalls here; the head byte stays counted
                    if (fifo_rd_valid && !busy) begin
                        state <= ST_SETUP;
                        cyc <= {`PPH_CYC_W{1'b0}};
                    end
                end
                ST_SETUP: begin
                    cyc <= cyc + 1'b1;
                    if (cyc == `PPH_STROBE_CYC - 1) begin
                        state <= ST_STROBE;
                        cyc <= {`PPH_CYC_W{1'b0}};
                        hw_strobe <= 1'b1;
                    end
                end
                ST_STROBE: begin
                    cyc <= cyc + 1'b1;
                    if (cyc == `PPH_STROBE_CYC - 1) begin
                        state <= ST_WAIT;
                        hw_strobe <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (!busy && n_ack) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (hit(reg_addr, `PPH_OFF_CTRL)) begin
                reg_rdata <= {2'h0, ctrl[5:0]};
            end else if (hit(reg_addr, `PPH_OFF_CFGA)) begin
                reg_rdata <= cfg_a;
            end else if (hit(reg_addr, `PPH_OFF_MODE)) begin
                reg_rdata <= {3'h0, fifo_full, fifo_empty, mode};
            end else if (hit(reg_addr, `PPH_OFF_DATA)) begin
                reg_rdata <= pd_oe ? pd_out : pd_in;
            end else if (hit(reg_addr, `PPH_OFF_DATA + 11'h001)) begin
                reg_rdata <= status;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule

// ### verif/pph_monitor.sv
// checker for pph_port, bound to its ports
// assumes one clock domain and a synchronous reset
`timescale 1ns/10ps
module pph_monitor #(
    parameter LEVEL_IRQ = 1'b0,
    parameter TRANSCEIVER_FLAG = 1'b1
) (
    input wire clk,
    input wire reset,
    input wire [10:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire [7:0] pd_out,
    input wire pd_oe,
    input wire n_strobe,
    input wire n_auto_fd,
    input wire n_reverse_request
);
    reg [2:0] mode;
    wire ctl_wr = reg_wr && reg_addr == 11'h002;
    always @(posedge clk) begin
        if (reset) mode <= 3'h0;
        else if (reg_wr && reg_addr == 11'h402) mode <= reg_wdata[2:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_cfg_rd;
        reg_rd && reg_addr == 11'h401;
    endsequence
    // override in fifo mode would also fall; bench keeps it off there
    sequence s_hw_strobe;
        $fell(n_strobe) && mode == 3'h2;
    endsequence
    chk_ctrl_override: assert property (ctl_wr && reg_wdata[1:0] == 2'h3 |=> !n_strobe && !n_auto_fd)
        else $error("override lost");
    chk_init_level: assert property (ctl_wr |=> n_reverse_request == $past(reg_wdata[2]))
        else $error("init level wrong");
    chk_ctrl_reserved: assert property (reg_rd && reg_addr == 11'h002 |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits set");
    chk_word_size: assert property (s_cfg_rd |=> reg_rdata[7:4] == {LEVEL_IRQ[0], 3'h1})
        else $error("id field wrong");
    chk_xcvr_flag: assert property (s_cfg_rd |=> reg_rdata[2:0] == {TRANSCEIVER_FLAG[0], 2'h0})
        else $error("flag wrong");
    chk_dir_ignored: assert property (mode == 3'h0 || mode == 3'h2 |-> pd_oe)
        else $error("drivers off");
    chk_strobe_width: assert property (s_hw_strobe |-> !n_strobe [*8])
        else $error("strobe short");
    chk_data_held: assert property (s_hw_strobe |-> pd_oe && $stable(pd_out))
        else $error("data moved");
endmodule
bind pph_port pph_monitor #(.LEVEL_IRQ(LEVEL_IRQ), .TRANSCEIVER_FLAG(TRANSCEIVER_FLAG)) i_mon (
    .clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .pd_out, .pd_oe, .n_strobe, .n_auto_fd, .n_reverse_request);

// ### verif/pph_periph.sv
// peripheral model on the cable side of pph_port
// answers strobes and the abort handshake; slow stretches busy
`timescale 1ns/10ps
module pph_periph (
    input wire clk,
    input wire reset,
    input wire slow,
    input wire n_strobe,
    input wire n_reverse_request,
    output reg n_ack,
    output reg busy,
    output reg n_ack_reverse,
    output wire n_periph_request,
    output wire select
);
    reg [3:0] cnt;
    assign n_periph_request = 1'b0;
    assign select = 1'b1;
    always @(posedge clk) begin
        if (reset) begin
            {n_ack, busy, n_ack_reverse, cnt} <= 7'h50;
        end else begin
            n_ack_reverse <= n_reverse_request;
            n_ack <= cnt != 4'h1;
            if (!n_reverse_request) begin
                {busy, cnt} <= 5'h00;
            end else if (!n_strobe) begin
                busy <= 1'b1;
                cnt <= slow ? 4'hF : 4'h2;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else begin
                busy <= 1'b0;
            end
        end
    end
endmodule

// ### verif/pph_port_bench.sv
// bench for pph_port with the peripheral model on the cable
// one 40 MHz clock; inputs move on the falling edge
`timescale 1ns/10ps
module pph_port_bench;
    reg clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    reg [10:0] reg_addr = 11'h000;
    reg [7:0] reg_wdata = 8'h00;
    reg [7:0] v;
    integer n_errors = 0;
    integer comparisons = 0;
    wire [7:0] reg_rdata, pd_out, pd_in;
    wire pd_oe, n_strobe, n_auto_fd, n_reverse_request, n_ack, busy, n_ack_reverse, n_periph_request, select;
    wire reg_wr_ready;
    // released bus reads inverted so stale data cannot pass
    assign pd_in = pd_oe ? pd_out : ~pd_out;
    pph_port #(.LEVEL_IRQ(1'b1)) i_pph_port (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_wr_ready, .pd_in, .pd_out, .pd_oe, .n_strobe, .n_auto_fd, .n_reverse_request, .n_select_in(),
        .n_ack, .busy, .n_ack_reverse, .n_periph_request, .select);
    pph_periph i_pph_periph (.clk, .reset, .slow, .n_strobe, .n_reverse_request, .n_ack, .busy,
        .n_ack_reverse, .n_periph_request, .select);
    initial forever #12.5 clk = ~clk;
    task chk(input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task wr(input [10:0] a, input [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input [10:0] a);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask
    task wait_strobe(input lvl);
        for (int i = 0; i < 300 && n_strobe !== lvl; i++) @(negedge clk);
        chk({7'h00, n_strobe}, {7'h00, lvl});
    endtask
    task poll(input lvl);
        rd(11'h001);
        for (int i = 0; i < 20 && v[5] !== lvl; i++) rd(11'h001);
        chk({7'h00, v[5]}, {7'h00, lvl});
    endtask
    task t_regs;
        rd(11'h002);
        chk(v, 8'h04);
        rd(11'h401);
        chk(v, 8'h94);
        wr(11'h401, 8'hF8);
        rd(11'h401);
        chk(v, 8'h9C);
        rd(11'h3FF);
        chk(v, 8'h00);
    endtask
    task t_override;
        wr(11'h002, 8'hC7);
        chk({6'h00, n_strobe, n_auto_fd}, 8'h00);
        rd(11'h002);
        chk(v, 8'h07);
        wr(11'h002, 8'h04);
    endtask
    task t_dir;
        wr(11'h000, 8'h3C);
        chk(pd_out, 8'h3C);
        for (int m = 0; m < 3; m++) begin
            wr(11'h402, m[7:0]);
            wr(11'h002, 8'h24);
            chk({7'h00, pd_oe}, {7'h00, m != 1});
            rd(11'h000);
            chk(v, (m == 1) ? 8'hC3 : 8'h3C);
            wr(11'h002, 8'h04);
        end
    endtask
    task t_fifo;
        wr(11'h402, 8'h02);
        wr(11'h400, 8'h5A);
        wr(11'h400, 8'hA5);
        for (int k = 0; k < 2; k++) begin
            slow = k[0];
            wait_strobe(1'b0);
            chk(pd_out, k ? 8'hA5 : 8'h5A);
            chk({7'h00, pd_oe}, 8'h01);
            wait_strobe(1'b1);
        end
        wr(11'h402, 8'h00);
        rd(11'h402);
        chk(v, 8'h08);
        // head byte sits in the output register yet still counts toward full
        wr(11'h402, 8'h02);
        repeat (16) wr(11'h400, 8'h3C);
        rd(11'h402);
        chk(v, 8'h12);
        chk({7'h00, reg_wr_ready}, 8'h00);
        wait_strobe(1'b0);
        wait_strobe(1'b1);
        wr(11'h402, 8'h00);
    endtask
    task t_abort;
        wr(11'h002, 8'h04);
        wr(11'h402, 8'h03);
        wr(11'h002, 8'h05);
        wr(11'h402, 8'h01);
        wr(11'h002, 8'h25);
        wr(11'h002, 8'h21);
        chk({7'h00, n_reverse_request}, 8'h00);
        poll(1'b0);
        chk({7'h00, v[7]}, 8'h01);
        wr(11'h002, 8'h20);
        wr(11'h002, 8'h24);
        chk({7'h00, n_reverse_request}, 8'h01);
        poll(1'b1);
        rd(11'h401);
        chk({6'h00, v[1:0]}, 8'h00);
    endtask
    task wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        t_regs;
        t_override;
        t_dir;
        t_fifo;
        t_abort;
        wrap_up;
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_errors = n_errors + 1;
        wrap_up;
    end
endmodule
